// ---- design/approach_band.sv ----
// Purpose: Approach test of a value against its reference in percent of a scale
// Assumes: Percent in 0.01 % steps, full scale 10000
// Notes: Cross-multiplied compare avoids a divider
`timescale 1ns/1ps
`default_nettype none
`include "freq_threshold_cfg.svh"
module approach_band #(
  parameter int W = 14
) (
  input wire logic [W-1:0] value,
  input wire logic [W-1:0] target,
  input wire logic [W-1:0] scale,
  input wire logic [13:0] ind_pct,
  input wire logic [13:0] hyst_pct,
  output logic within_on,
  output logic beyond_off
);

  logic [W-1:0] dev;
  logic [13:0] off_pct;
  logic [13:0] slack_on;
  logic [13:0] slack_off;
  logic [W+13:0] dev_scaled;

  always_comb begin
    dev = (value >= target) ? (value - target) : (target - value);
    off_pct = (ind_pct > hyst_pct) ? (ind_pct - hyst_pct) : 14'h0000;
    slack_on = (ind_pct < `FT_PCT_FULL) ? (`FT_PCT_FULL - ind_pct) : 14'h0000;
    slack_off = (off_pct < `FT_PCT_FULL) ? (`FT_PCT_FULL - off_pct) : 14'h0000;
    dev_scaled = (W + 14)'(dev) * (W + 14)'(`FT_PCT_FULL);
  end

  // Deviation within (100 % - indication) of scale turns on
  assign within_on = dev_scaled <= (W + 14)'(slack_on) * (W + 14)'(scale);
  // Off only past the band widened by the hysteresis
  assign beyond_off = dev_scaled > (W + 14)'(slack_off) * (W + 14)'(scale);

endmodule : approach_band
`default_nettype wire

// ---- design/contact_latch.sv ----
// Purpose: Hysteresis state of one output and its contact level
// Assumes: eval is a one-cycle pulse on ref_clk
// Notes: Set has priority over clear
`timescale 1ns/1ps
`default_nettype none
module contact_latch (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic eval,
  input wire logic set_cond,
  input wire logic clr_cond,
  input wire logic invert,
  output logic active_reg,
  output logic contact_reg
);

  logic active_next;

  always_comb begin
    active_next = active_reg;
    if (set_cond) begin
      active_next = 1'b1;
    end else if (clr_cond) begin
      active_next = 1'b0;
    end
  end

  // State only moves on an evaluation, so stale inputs between updates do nothing
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      active_reg <= 1'b0;
    end else if (eval) begin
      active_reg <= active_next;
    end
  end

  // Polarity follows the settings every cycle, so a change shows on the next edge
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      contact_reg <= 1'b0;
    end else begin
      contact_reg <= active_reg ^ invert;
    end
  end

endmodule : contact_latch
`default_nettype wire

// ---- design/freq_threshold_cfg.svh ----
// Purpose: Register map, field positions, reset values and scales of the threshold outputs
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, frequencies in 0.1 Hz, percent in 0.01 %
// Notes: Definitions only
`ifndef FREQ_THRESHOLD_CFG_SVH
`define FREQ_THRESHOLD_CFG_SVH

`define FT_OFS_CTRL 8'h00
`define FT_OFS_MAX_FREQ 8'h04
`define FT_OFS_APP_IND 8'h08
`define FT_OFS_APP_HYST 8'h0C
`define FT_OFS_OVER_THR 8'h10
`define FT_OFS_OVER_HYST 8'h14
`define FT_OFS_WIN_LOWER 8'h18
`define FT_OFS_WIN_UPPER 8'h1C
`define FT_OFS_WIN_HYST 8'h20
`define FT_OFS_STATUS 8'h24

`define FT_CTRL_REGULATION 0
`define FT_CTRL_APP_BREAK 1
`define FT_CTRL_OVER_BREAK 2
`define FT_CTRL_WIN_BREAK 3
`define FT_CTRL_WIN_OUTSIDE 4
`define FT_CTRL_W 5

`define FT_STAT_APP_ACTIVE 0
`define FT_STAT_OVER_ACTIVE 1
`define FT_STAT_WIN_ACTIVE 2
`define FT_STAT_APP_CONTACT 3
`define FT_STAT_OVER_CONTACT 4
`define FT_STAT_WIN_CONTACT 5

`define FT_RST_CTRL 5'h00
`define FT_RST_MAX_FREQ 14'h01F4
`define FT_RST_APP_IND 14'h26AC
`define FT_RST_APP_HYST 14'h0064
`define FT_RST_OVER_THR 14'h0064
`define FT_RST_OVER_HYST 14'h000A
`define FT_RST_WIN_LOWER 14'h0190
`define FT_RST_WIN_UPPER 14'h01F4
`define FT_RST_WIN_HYST 14'h000A

// Full scale of a percentage, 100.00 % in 0.01 % steps
`define FT_PCT_FULL 14'h2710

`endif

// ---- design/freq_threshold_pkg.sv ----
// Purpose: Types shared by the threshold output block
// Assumes: 14-bit frequency and percent values
// Notes: Numbers live in freq_threshold_cfg.svh
package freq_threshold_pkg;

  typedef logic [13:0] value_t;

  // One update of the converter's internal values
  typedef struct packed {
    value_t out_freq;
    value_t freq_ref;
    value_t feedback;
    value_t setpoint;
  } drive_sample_s;

  // Contact state of the three outputs
  typedef struct packed {
    logic approach;
    logic over_freq;
    logic window;
  } contact_s;

endpackage : freq_threshold_pkg

// ---- design/frequency_threshold_outputs.sv ----
// Purpose: Three relay outputs: approach to reference, over-frequency and frequency window
// Assumes: Samples come from logic on ref_clk; registers reached over Avalon-MM
// Notes: Frequencies in 0.1 Hz, percentages in 0.01 %
//
// Behaviour
// - Control mode: approach output on when frequency near reference, 1 % = fmax/100.
// - Regulation mode: approach output on when feedback within indication percent of reference.
// - Approach output turns off only beyond indication minus hysteresis.
// - Each output has selectable operating or breaking polarity, default operating.
// - Over-frequency output turns on when frequency exceeds the threshold.
// - Over-frequency output stays on until frequency falls below threshold minus hysteresis.
// - If threshold minus hysteresis is negative, turn off only at 0 Hz.
// - Window output follows whether frequency lies between lower and upper limits.
// - Rising frequency: on at lower limit, off above upper limit plus hysteresis.
// - Falling frequency: on at upper limit, off below lower limit minus hysteresis.
// - If lower limit minus hysteresis is negative, window turns off only at 0 Hz.
// - Window output selectable as contact for inside or for outside the interval.
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`default_nettype none
`include "freq_threshold_cfg.svh"
module frequency_threshold_outputs #(
  parameter int W = 14
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic sample_valid,
  input wire freq_threshold_pkg::drive_sample_s sample,
  output freq_threshold_pkg::contact_s contacts
);

  // Settings
  logic [`FT_CTRL_W-1:0] ctrl_reg;
  logic [W-1:0] max_freq_reg;
  logic [13:0] app_ind_reg;
  logic [13:0] app_hyst_reg;
  logic [W-1:0] over_thr_reg;
  logic [W-1:0] over_hyst_reg;
  logic [W-1:0] win_lower_reg;
  logic [W-1:0] win_upper_reg;
  logic [W-1:0] win_hyst_reg;

  // Bus handshake
  logic wait_reg;
  logic [31:0] rdata_reg;
  logic req;
  logic accept;
  logic [31:0] rdata_next;

  // Latched sample and evaluation strobe
  freq_threshold_pkg::drive_sample_s sample_reg;
  logic eval_reg;

  // Comparison terms
  logic [W-1:0] app_value;
  logic [W-1:0] app_target;
  logic [W-1:0] app_scale;
  logic app_on;
  logic app_off;
  logic over_set;
  logic over_clr;
  logic win_inside;
  logic win_clr;
  logic win_invert;
  logic [W:0] upper_plus;
  logic app_active;
  logic over_active;
  logic win_active;
  logic app_contact;
  logic over_contact;
  logic win_contact;

  assign req = read | write;
  // A request is served on the second edge it is seen, with waitrequest low in between
  assign accept = req & ~wait_reg;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      wait_reg <= 1'b1;
    end else if (accept) begin
      wait_reg <= 1'b1;
    end else if (req) begin
      wait_reg <= 1'b0;
    end
  end

  always_comb begin
    rdata_next = 32'h0000_0000;
    unique case (address)
      `FT_OFS_CTRL: rdata_next[`FT_CTRL_W-1:0] = ctrl_reg;
      `FT_OFS_MAX_FREQ: rdata_next[W-1:0] = max_freq_reg;
      `FT_OFS_APP_IND: rdata_next[13:0] = app_ind_reg;
      `FT_OFS_APP_HYST: rdata_next[13:0] = app_hyst_reg;
      `FT_OFS_OVER_THR: rdata_next[W-1:0] = over_thr_reg;
      `FT_OFS_OVER_HYST: rdata_next[W-1:0] = over_hyst_reg;
      `FT_OFS_WIN_LOWER: rdata_next[W-1:0] = win_lower_reg;
      `FT_OFS_WIN_UPPER: rdata_next[W-1:0] = win_upper_reg;
      `FT_OFS_WIN_HYST: rdata_next[W-1:0] = win_hyst_reg;
      `FT_OFS_STATUS: begin
        rdata_next[`FT_STAT_APP_ACTIVE] = app_active;
        rdata_next[`FT_STAT_OVER_ACTIVE] = over_active;
        rdata_next[`FT_STAT_WIN_ACTIVE] = win_active;
        rdata_next[`FT_STAT_APP_CONTACT] = app_contact;
        rdata_next[`FT_STAT_OVER_CONTACT] = over_contact;
        rdata_next[`FT_STAT_WIN_CONTACT] = win_contact;
      end
      default: rdata_next = 32'h0000_0000;
    endcase
  end

  // Read data is captured one edge early so it stands when waitrequest is low
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
    end else if (read && wait_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign readdata = rdata_reg;
  assign waitrequest = wait_reg;

  // Writes land on the accepting edge; unmapped and status addresses are ignored
  logic wr_en;
  assign wr_en = accept & write;

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_reg <= `FT_RST_CTRL;
    end else if (wr_en && address == `FT_OFS_CTRL) begin
      ctrl_reg <= writedata[`FT_CTRL_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      max_freq_reg <= `FT_RST_MAX_FREQ;
    end else if (wr_en && address == `FT_OFS_MAX_FREQ) begin
      max_freq_reg <= writedata[W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      app_ind_reg <= `FT_RST_APP_IND;
    end else if (wr_en && address == `FT_OFS_APP_IND) begin
      app_ind_reg <= writedata[13:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      app_hyst_reg <= `FT_RST_APP_HYST;
    end else if (wr_en && address == `FT_OFS_APP_HYST) begin
      app_hyst_reg <= writedata[13:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      over_thr_reg <= `FT_RST_OVER_THR;
    end else if (wr_en && address == `FT_OFS_OVER_THR) begin
      over_thr_reg <= writedata[W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      over_hyst_reg <= `FT_RST_OVER_HYST;
    end else if (wr_en && address == `FT_OFS_OVER_HYST) begin
      over_hyst_reg <= writedata[W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      win_lower_reg <= `FT_RST_WIN_LOWER;
    end else if (wr_en && address == `FT_OFS_WIN_LOWER) begin
      win_lower_reg <= writedata[W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      win_upper_reg <= `FT_RST_WIN_UPPER;
    end else if (wr_en && address == `FT_OFS_WIN_UPPER) begin
      win_upper_reg <= writedata[W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      win_hyst_reg <= `FT_RST_WIN_HYST;
    end else if (wr_en && address == `FT_OFS_WIN_HYST) begin
      win_hyst_reg <= writedata[W-1:0];
    end
  end

  // Sample is held so all three tests see one consistent set of values
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      sample_reg <= '0;
    end else if (sample_valid) begin
      sample_reg <= sample;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      eval_reg <= 1'b0;
    end else begin
      eval_reg <= sample_valid;
    end
  end

  // Control compares frequency to its reference in fmax percent; regulation uses 0.01 % units
  always_comb begin
    if (ctrl_reg[`FT_CTRL_REGULATION]) begin
      app_value = sample_reg.feedback;
      app_target = sample_reg.setpoint;
      app_scale = W'(`FT_PCT_FULL);
    end else begin
      app_value = sample_reg.out_freq;
      app_target = sample_reg.freq_ref;
      app_scale = max_freq_reg;
    end
  end

  approach_band #(
    .W(W)
  ) u_approach_band (
    .value(app_value),
    .target(app_target),
    .scale(app_scale),
    .ind_pct(app_ind_reg),
    .hyst_pct(app_hyst_reg),
    .within_on(app_on),
    .beyond_off(app_off)
  );

  // Floor at 0 Hz once the hysteresis reaches the threshold, so the output cannot stick on
  always_comb begin
    over_set = sample_reg.out_freq > over_thr_reg;
    if (over_thr_reg > over_hyst_reg) begin
      over_clr = sample_reg.out_freq < (over_thr_reg - over_hyst_reg);
    end else begin
      over_clr = sample_reg.out_freq == '0;
    end
  end

  // Window: on anywhere inside, so entry from below or above sets it
  always_comb begin
    upper_plus = {1'b0, win_upper_reg} + {1'b0, win_hyst_reg};
    win_inside = (sample_reg.out_freq >= win_lower_reg) &&
                 (sample_reg.out_freq <= win_upper_reg);
    win_clr = {1'b0, sample_reg.out_freq} > upper_plus;
    if (win_lower_reg > win_hyst_reg) begin
      if (sample_reg.out_freq < (win_lower_reg - win_hyst_reg)) begin
        win_clr = 1'b1;
      end
    end else if (sample_reg.out_freq == '0) begin
      win_clr = 1'b1;
    end
    // Outside mode turns the contact round before the polarity choice
    win_invert = ctrl_reg[`FT_CTRL_WIN_OUTSIDE] ^ ctrl_reg[`FT_CTRL_WIN_BREAK];
  end

  contact_latch u_app_latch (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .eval(eval_reg),
    .set_cond(app_on),
    .clr_cond(app_off),
    .invert(ctrl_reg[`FT_CTRL_APP_BREAK]),
    .active_reg(app_active),
    .contact_reg(app_contact)
  );

  contact_latch u_over_latch (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .eval(eval_reg),
    .set_cond(over_set),
    .clr_cond(over_clr),
    .invert(ctrl_reg[`FT_CTRL_OVER_BREAK]),
    .active_reg(over_active),
    .contact_reg(over_contact)
  );

  contact_latch u_win_latch (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .eval(eval_reg),
    .set_cond(win_inside),
    .clr_cond(win_clr),
    .invert(win_invert),
    .active_reg(win_active),
    .contact_reg(win_contact)
  );

  assign contacts.approach = app_contact;
  assign contacts.over_freq = over_contact;
  assign contacts.window = win_contact;

endmodule : frequency_threshold_outputs
`default_nettype wire

// ---- sim/contact_load.sv ----
// Purpose: Equipment wired to the three contacts
// Assumes: Contacts are plain levels on ref_clk
// Notes: Counts switching events only; it never drives the block
`timescale 1ns/1ps
`default_nettype none
module contact_load (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire freq_threshold_pkg::contact_s contacts,
  output int switch_count
);
  freq_threshold_pkg::contact_s last_reg;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      last_reg <= '0;
      switch_count <= 0;
    end else begin
      last_reg <= contacts;
      if (contacts != last_reg) switch_count <= switch_count + 1;
    end
  end
endmodule : contact_load
`default_nettype wire

// ---- sim/freq_threshold_properties.sv ----
// Purpose: Port-level checks of the threshold output block
// Assumes: One clock domain, nrst asynchronous active low
// Notes: Bound to the top module at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module freq_threshold_properties (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic sample_valid,
  input wire freq_threshold_pkg::drive_sample_s sample,
  input wire freq_threshold_pkg::contact_s contacts
);
  logic over_break_reg;
  logic done;
  assign done = write && !waitrequest;
  // Shadow of the over-frequency polarity bit, so the zero check knows the idle level
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) over_break_reg <= 1'b0;
    else if (done && address == 8'h00) over_break_reg <= writedata[2];
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  sequence s_answer;
    !waitrequest ##1 waitrequest;
  endsequence
  a_idle_wait: assert property (!read && !write |-> waitrequest)
    else $error("waitrequest low with no request");
  a_answer_once: assert property ((read || write) && waitrequest |=> s_answer)
    else $error("wait cycle count wrong");
  a_unmapped_zero: assert property (read && waitrequest && address > 8'h24 |=>
    readdata == 32'h0000_0000) else $error("unmapped read not zero");
  a_upper_zero: assert property (read && !waitrequest |-> readdata[31:14] == 18'h0_0000)
    else $error("upper read bits not zero");
  a_read_hold: assert property (!read |=> $stable(readdata))
    else $error("readdata changed without read");
  a_status_mirror: assert property (read && waitrequest && address == 8'h24 |=>
    readdata[5:3] == {$past(contacts.window), $past(contacts.over_freq),
    $past(contacts.approach)}) else $error("status contact bits differ");
  a_contact_cause: assert property ($changed(contacts) |-> $past(sample_valid) ||
    $past(sample_valid, 2) || $past(sample_valid, 3) || $past(done) || $past(done, 2))
    else $error("contacts changed without cause");
  a_over_zero: assert property (sample_valid && sample.out_freq == 14'h0000 |->
    ##3 contacts.over_freq == over_break_reg) else $error("over output on at zero");
endmodule : freq_threshold_properties
bind frequency_threshold_outputs freq_threshold_properties u_props (
  .ref_clk(ref_clk), .nrst(nrst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .sample_valid(sample_valid), .sample(sample), .contacts(contacts));
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: Self-checking bench of the threshold outputs against an integer model
// Assumes: Avalon master waits on waitrequest; sample latency fixed by the design
// Notes: Model state is kept in cfg, app, over and win
`timescale 1ns/1ps
`default_nettype none
`include "freq_threshold_cfg.svh"
module tb;
  logic ref_clk;
  logic nrst;
  logic [7:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic waitrequest;
  logic sample_valid;
  freq_threshold_pkg::drive_sample_s sample;
  freq_threshold_pkg::contact_s contacts;
  int n_fail;
  int comparisons;
  int switch_count;
  int seed;
  int cfg[10];
  int app;
  int over;
  int win;
  logic [31:0] rd;

  frequency_threshold_outputs dut (.ref_clk(ref_clk), .nrst(nrst), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sample_valid(sample_valid), .sample(sample),
    .contacts(contacts));
  contact_load load (.ref_clk(ref_clk), .nrst(nrst), .contacts(contacts),
    .switch_count(switch_count));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    $display("n_fail=%0d comparisons=%0d", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("FAIL at %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Entered right after a rising edge; the extra edge at the end keeps drivers single
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int i;
    write <= wr;
    read <= !wr;
    address <= a;
    writedata <= d;
    for (i = 0; i < 20; i++) begin
      @(posedge ref_clk);
      if (waitrequest === 1'b0) break;
    end
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (i == 20) begin
      n_fail++;
      test_done();
    end
    @(posedge ref_clk);
  endtask : bus

  task automatic wr_reg(input int idx, input int v);
    bus(1'b1, 8'(idx * 4), 32'(v), rd);
    if (idx < 9) cfg[idx] = v & (idx == 0 ? 31 : 16383);
  endtask : wr_reg

  function automatic int appr(int v, int t, int sc, int st);
    int dev;
    int lo;
    dev = v > t ? v - t : t - v;
    lo = cfg[2] > cfg[3] ? cfg[2] - cfg[3] : 0;
    if (dev * 10000 <= (10000 - cfg[2]) * sc) return 1;
    if (dev * 10000 > (10000 - lo) * sc) return 0;
    return st;
  endfunction : appr

  task automatic verify;
    logic [2:0] e;
    e = {app[0], over[0], win[0]} ^ {cfg[0][1], cfg[0][2], cfg[0][3] ^ cfg[0][4]};
    check(32'(contacts), 32'(e));
    bus(1'b0, 8'h24, 32'h0000_0000, rd);
    check(32'(rd[5:0]), 32'({e[0], e[1], e[2], win[0], over[0], app[0]}));
  endtask : verify

  task automatic step(input int f, input int r, input int fb, input int sp);
    sample_valid <= 1'b1;
    sample <= {14'(f), 14'(r), 14'(fb), 14'(sp)};
    @(posedge ref_clk);
    sample_valid <= 1'b0;
    app = cfg[0][0] ? appr(fb, sp, 10000, app) : appr(f, r, cfg[1], app);
    if (f > cfg[4]) over = 1;
    else if (cfg[5] >= cfg[4] ? f == 0 : f < cfg[4] - cfg[5]) over = 0;
    if (f >= cfg[6] && f <= cfg[7]) win = 1;
    else if (f > cfg[7] + cfg[8] ||
             (cfg[8] >= cfg[6] ? f == 0 : f < cfg[6] - cfg[8])) win = 0;
    repeat (3) @(posedge ref_clk);
    verify();
  endtask : step

  task automatic sweep(input int r, input int q[$]);
    foreach (q[i]) step(q[i], r, 0, 0);
  endtask : sweep

  initial begin
    #400000;
    n_fail++;
    test_done();
  end

  initial begin
    nrst = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    sample_valid = 1'b0;
    sample = '0;
    n_fail = 0;
    comparisons = 0;
    seed = 3;
    app = 0;
    over = 0;
    win = 0;
    cfg = '{`FT_RST_CTRL, `FT_RST_MAX_FREQ, `FT_RST_APP_IND, `FT_RST_APP_HYST,
      `FT_RST_OVER_THR, `FT_RST_OVER_HYST, `FT_RST_WIN_LOWER, `FT_RST_WIN_UPPER,
      `FT_RST_WIN_HYST, 0};
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    // Reset values, unmapped, unaligned and read-only places
    wr_reg(9, 63);
    wr_reg(12, 7);
    for (int i = 0; i < 13; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0000_0000, rd);
      check(rd, i < 10 ? 32'(cfg[i]) : 32'h0000_0000);
    end
    bus(1'b0, 8'h02, 32'h0000_0000, rd);
    check(rd, 32'h0000_0000);
    $display("register map test done");
    sweep(0, '{100, 101, 95, 90, 89, 95, 101, 0});
    wr_reg(4, 5);
    sweep(0, '{6, 1, 0});
    wr_reg(4, 100);
    $display("over frequency test done");
    sweep(0, '{390, 400, 450, 500, 510, 511, 505, 450, 390, 389, 500, 0});
    wr_reg(6, 5);
    sweep(0, '{6, 1, 0});
    wr_reg(6, 400);
    $display("window test done");
    sweep(300, '{294, 295, 305, 310, 311, 300, 289});
    wr_reg(0, 1);
    foreach (cfg[i]) if (i < 6) step(0, 0, 5200 - i * 100 - (i == 5), 5000);
    $display("approach test done");
    step(450, 450, 0, 0);
    for (int c = 0; c < 32; c++) begin
      wr_reg(0, c);
      repeat (2) @(posedge ref_clk);
      verify();
    end
    $display("polarity test done");
    // Random settings interleaved with samples: each write must act on the next sample
    repeat (40) begin
      int idx;
      idx = {$random(seed)} % 9;
      wr_reg(idx, {$random(seed)} % (idx == 0 ? 32 : (idx == 2 || idx == 3) ? 10001 : 1001));
      step({$random(seed)} % 1200, {$random(seed)} % 1200, {$random(seed)} % 10001,
           {$random(seed)} % 10001);
    end
    // Every setting written above must read back as the model holds it
    for (int i = 0; i < 9; i++) begin
      bus(1'b0, 8'(i * 4), 32'h0000_0000, rd);
      check(rd, 32'(cfg[i]));
    end
    $display("random test done");
    check(32'(switch_count > 0), 32'h0000_0001);
    test_done();
  end
endmodule : tb
`default_nettype wire
